// ==== scl_cmd.sv ====
// Functional notes
// - Security writes only in upper sixteen bytes
// - Security pages wrap like array pages
// - Opcode Bh writes: ack address, data bytes
// - Write cycle begins only after stop
// - Security addressing ignores A7 to A5
// - Lock: opcode 2h, A7..A4 equal 6h
// - Lock acks address and data if unlocked
// - Lock commits on stop after data only
// - Completed lock makes register permanently read-only
// - Locked: ack device address, nack memory address, ready
// - Lock check: ack unlocked, nack locked
// - Reset and discovery select high speed
// - Dh write: ack, go standard speed
// - Dh read: ack only if standard speed
// - Eh write: ack, go high speed
// - Eh read: ack only if high speed
// - One shared pointer, advances past access
// - Pointer wraps to 00h within region
// - Pointer kept, cleared by reset
// - Stop off byte boundary aborts write
// - Busy blocks commands, nacks short pulses
// - Page writes increment low three bits
`timescale 1ns/1ns
`include "scl_map.svh"

module scl_cmd
    import scl_pkg::*;
#(
    parameter int WR_TIME_US = `SCL_WR_TIME_US,           // Write cycle time in microseconds
    parameter int WR_CYCLES  = WR_TIME_US * `SCL_CLK_MHZ  // Write cycle time in clocks
)
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [2:0] SLAVE_ID,
    input  wire logic       LOCK_NV,
    input  wire logic       DISC_RESET,
    input  wire logic       START,
    input  wire logic       STOP,
    input  wire logic       STOP_MIDBYTE,
    input  wire logic       BYTE_VALID,
    input  wire logic [7:0] BYTE_DATA,
    input  wire logic       RD_BYTE_DONE,
    input  wire logic       LOW_PULSE,
    input  wire logic       ABORT_LONG,
    output logic            ACK_VALID,
    output logic            ACK_OK,
    output logic            WDAT_VALID,
    output logic [6:0]      WDAT_ADDR,
    output logic            WDAT_SEC,
    output logic [7:0]      WDAT,
    output logic            PROG_GO,
    output logic [1:0]      PROG_KIND,
    output logic            PROG_ABORT,
    output logic            PROG_DONE,
    output logic            BUSY,
    output logic            LOCKED,
    output logic            HIGH_SPEED,
    output logic [6:0]      PTR_ADDR,
    output logic            PTR_SEC
);

    scl_cmd_s_t s_q;            // Registered sequencer state
    scl_cmd_s_t s_d;            // Next sequencer state
    logic       ptr_clr;        // Clear pointer to 00h
    logic       ptr_load;       // Load pointer from address byte
    logic [6:0] ptr_load_addr;  // Address to load
    logic       ptr_load_sec;   // Region to load
    logic       ptr_page;       // Page increment after data byte
    logic       ptr_seq;        // Sequential increment after read byte
    logic [6:0] ptr_addr;       // Current pointer
    logic       ptr_sec;        // Current pointer region
    logic [3:0] op;             // Opcode field of incoming byte
    logic [2:0] sid;            // Slave id field of incoming byte
    logic       rd;             // Direction bit of incoming byte

    localparam logic [31:0] WR_CNT = 32'(WR_CYCLES); // Busy length in clocks

    // Device address byte fields
    assign op  = BYTE_DATA[`SCL_OP_MSB:`SCL_OP_LSB];
    assign sid = BYTE_DATA[`SCL_SID_MSB:`SCL_SID_LSB];
    assign rd  = BYTE_DATA[`SCL_RW_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Shared address pointer
    scl_ptr u_ptr (
        .clk       (CLK),
        .rst       (RST),
        .clr       (ptr_clr),
        .load      (ptr_load),
        .load_addr (ptr_load_addr),
        .load_sec  (ptr_load_sec),
        .page_inc  (ptr_page),
        .seq_inc   (ptr_seq),
        .ptr_addr  (ptr_addr),
        .ptr_sec   (ptr_sec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_comb begin
        s_d            = s_q;
        s_d.ack_vld    = 1'b0;
        s_d.wdat_vld   = 1'b0;
        s_d.prog_go    = 1'b0;
        s_d.prog_abort = 1'b0;
        s_d.prog_done  = 1'b0;
        // Lock state only ever sets
        s_d.locked     = s_q.locked | LOCK_NV;
        ptr_clr        = 1'b0;
        ptr_load       = 1'b0;
        ptr_load_addr  = `SCL_PTR_RST;
        ptr_load_sec   = 1'b0;
        ptr_page       = 1'b0;
        // Reads handled outside advance the pointer
        ptr_seq        = RD_BYTE_DONE && (s_q.state == SCL_ST_READ);

        if (s_q.state == SCL_ST_BUSY) begin
            // Internal write cycle in progress
            s_d.timer = s_q.timer - 32'h1;
            if (LOW_PULSE) begin
                // Short pulse answered busy
                s_d.ack_vld = 1'b1;
                s_d.ack_ok  = 1'b0;
            end
            if (ABORT_LONG) begin
                // Long low terminates the cycle
                s_d.prog_abort = 1'b1;
                s_d.state      = SCL_ST_IDLE;
                s_d.busy       = 1'b0;
            end else if (s_q.timer <= 32'h1) begin
                // Cycle complete
                s_d.prog_done = 1'b1;
                s_d.state     = SCL_ST_IDLE;
                s_d.busy      = 1'b0;
                if (s_q.kind == SCL_K_LOCK) begin
                    s_d.locked = 1'b1;
                end
            end
        end else if (DISC_RESET) begin
            // Reset with discovery response
            s_d.hs    = `SCL_HS_RST;
            s_d.state = SCL_ST_IDLE;
            ptr_clr   = 1'b1;
            if (s_q.have_data) begin
                s_d.prog_abort = 1'b1;
            end
            s_d.have_data = 1'b0;
        end else if (START) begin
            // New command; staged write data is dropped
            if (s_q.have_data) begin
                s_d.prog_abort = 1'b1;
            end
            s_d.have_data = 1'b0;
            s_d.state     = SCL_ST_DEV;
        end else if (STOP) begin
            s_d.state = SCL_ST_IDLE;
            case (s_q.state)
                SCL_ST_DATA: begin
                    if (s_q.have_data && !STOP_MIDBYTE) begin
                        // Commit staged bytes
                        s_d.prog_go   = 1'b1;
                        s_d.prog_kind = s_q.kind;
                        s_d.state     = SCL_ST_BUSY;
                        s_d.busy      = 1'b1;
                        s_d.timer     = WR_CNT;
                    end else if (s_q.have_data) begin
                        s_d.prog_abort = 1'b1;
                    end
                end
                SCL_ST_LKSTOP: begin
                    if (!STOP_MIDBYTE) begin
                        // Lock commit after data byte
                        s_d.prog_go   = 1'b1;
                        s_d.prog_kind = SCL_K_LOCK;
                        s_d.kind      = SCL_K_LOCK;
                        s_d.state     = SCL_ST_BUSY;
                        s_d.busy      = 1'b1;
                        s_d.timer     = WR_CNT;
                    end
                end
                default: begin
                    // Stop elsewhere ends the command
                    s_d.state = SCL_ST_IDLE;
                end
            endcase
            s_d.have_data = 1'b0;
        end else if (BYTE_VALID) begin
            case (s_q.state)
                SCL_ST_DEV: begin
                    // Device address byte
                    s_d.ack_vld = 1'b1;
                    s_d.ack_ok  = 1'b0;
                    s_d.state   = SCL_ST_SKIP;
                    if (sid == SLAVE_ID) begin
                        case (op)
                            `SCL_OP_EEPROM, `SCL_OP_SECREG: begin
                                s_d.ack_ok = 1'b1;
                                s_d.kind   = (op == `SCL_OP_SECREG) ? SCL_K_SEC : SCL_K_EE;
                                s_d.state  = rd ? SCL_ST_READ : SCL_ST_MADDR;
                            end
                            `SCL_OP_LOCK: begin
                                if (!rd) begin
                                    s_d.ack_ok = 1'b1;
                                    s_d.kind   = SCL_K_LOCK;
                                    s_d.state  = SCL_ST_MADDR;
                                end
                            end
                            `SCL_OP_STD_SPEED: begin
                                if (rd) begin
                                    s_d.ack_ok = !s_q.hs;
                                end else begin
                                    s_d.ack_ok = 1'b1;
                                    s_d.hs     = 1'b0;
                                end
                            end
                            `SCL_OP_HIGH_SPEED: begin
                                if (rd) begin
                                    s_d.ack_ok = s_q.hs;
                                end else begin
                                    s_d.ack_ok = 1'b1;
                                    s_d.hs     = 1'b1;
                                end
                            end
                            default: begin
                                // Unsupported here: not acknowledged
                                s_d.ack_ok = 1'b0;
                            end
                        endcase
                    end
                end
                SCL_ST_MADDR: begin
                    // Memory address byte
                    s_d.ack_vld = 1'b1;
                    if (s_q.kind == SCL_K_LOCK) begin
                        if (BYTE_DATA[`SCL_LOCK_A_MSB:`SCL_LOCK_A_LSB] == `SCL_LOCK_ACODE
                                && !s_q.locked) begin
                            s_d.ack_ok = 1'b1;
                            s_d.state  = SCL_ST_LKDATA;
                        end else begin
                            s_d.ack_ok = 1'b0;
                            s_d.state  = SCL_ST_SKIP;
                        end
                    end else begin
                        s_d.ack_ok    = 1'b1;
                        s_d.state     = SCL_ST_DATA;
                        ptr_load      = 1'b1;
                        ptr_load_sec  = (s_q.kind == SCL_K_SEC);
                        ptr_load_addr = (s_q.kind == SCL_K_SEC)
                                      ? {2'b00, BYTE_DATA[`SCL_SEC_A_MSB:0]}
                                      : BYTE_DATA[6:0];
                    end
                end
                SCL_ST_DATA: begin
                    // Data byte of a write
                    s_d.ack_vld = 1'b1;
                    if (s_q.kind == SCL_K_SEC
                            && (s_q.locked || !ptr_addr[`SCL_SEC_USER_BIT])) begin
                        // Read-only security area refused
                        s_d.ack_ok = 1'b0;
                        if (s_q.have_data) begin
                            s_d.prog_abort = 1'b1;
                        end
                        s_d.have_data = 1'b0;
                        s_d.state     = SCL_ST_IDLE;
                    end else begin
                        s_d.ack_ok    = 1'b1;
                        s_d.have_data = 1'b1;
                        s_d.wdat_vld  = 1'b1;
                        s_d.wdat_addr = ptr_addr;
                        s_d.wdat_sec  = ptr_sec;
                        s_d.wdat      = BYTE_DATA;
                        ptr_page      = 1'b1;
                    end
                end
                SCL_ST_LKDATA: begin
                    // Don't-care data byte of lock
                    s_d.ack_vld = 1'b1;
                    s_d.ack_ok  = !s_q.locked;
                    s_d.state   = SCL_ST_LKSTOP;
                end
                SCL_ST_LKSTOP: begin
                    // Extra byte instead of stop aborts lock
                    s_d.ack_vld = 1'b1;
                    s_d.ack_ok  = 1'b0;
                    s_d.state   = SCL_ST_SKIP;
                end
                default: begin
                    // Read data and idle bytes not handled here
                    s_d.state = s_q.state;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q        <= '0;
            s_q.state  <= SCL_ST_IDLE;
            s_q.kind   <= SCL_K_EE;
            s_q.prog_kind <= SCL_K_EE;
            s_q.hs     <= `SCL_HS_RST;
            s_q.locked <= `SCL_LOCK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign ACK_VALID  = s_q.ack_vld;
    assign ACK_OK     = s_q.ack_ok;
    assign WDAT_VALID = s_q.wdat_vld;
    assign WDAT_ADDR  = s_q.wdat_addr;
    assign WDAT_SEC   = s_q.wdat_sec;
    assign WDAT       = s_q.wdat;
    assign PROG_GO    = s_q.prog_go;
    assign PROG_KIND  = s_q.prog_kind;
    assign PROG_ABORT = s_q.prog_abort;
    assign PROG_DONE  = s_q.prog_done;
    assign BUSY       = s_q.busy;
    assign LOCKED     = s_q.locked;
    assign HIGH_SPEED = s_q.hs;
    assign PTR_ADDR   = ptr_addr;
    assign PTR_SEC    = ptr_sec;

endmodule : scl_cmd

// ==== scl_map.svh ====
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

// Device address byte fields
`define SCL_OP_MSB          7
`define SCL_OP_LSB          4
`define SCL_SID_MSB         3
`define SCL_SID_LSB         1
`define SCL_RW_BIT          0

// Opcodes (upper nibble of the device address byte)
`define SCL_OP_EEPROM       4'hA
`define SCL_OP_SECREG       4'hB
`define SCL_OP_LOCK         4'h2
`define SCL_OP_STD_SPEED    4'hD
`define SCL_OP_HIGH_SPEED   4'hE

// Lock and lock-check memory address code in A7..A4
`define SCL_LOCK_ACODE      4'h6
`define SCL_LOCK_A_MSB      7
`define SCL_LOCK_A_LSB      4

// Region sizes and address fields
`define SCL_EE_LAST         7'h7F
`define SCL_SEC_LAST        5'h1F
`define SCL_SEC_A_MSB       4
`define SCL_SEC_USER_BIT    4
`define SCL_PAGE_BITS       3

// Reset values
`define SCL_PTR_RST         7'h00
`define SCL_HS_RST          1'b1
`define SCL_LOCK_RST        1'b0

// Write cycle time and clock rate
`define SCL_CLK_MHZ         250
`define SCL_WR_TIME_US      1000

`endif

// ==== scl_pkg.sv ====
package scl_pkg;

    // Command sequencer states
    typedef enum logic [3:0] {
        SCL_ST_IDLE,
        SCL_ST_DEV,
        SCL_ST_MADDR,
        SCL_ST_DATA,
        SCL_ST_LKDATA,
        SCL_ST_LKSTOP,
        SCL_ST_READ,
        SCL_ST_SKIP,
        SCL_ST_BUSY
    } scl_state_t;

    // Target of the current write sequence
    typedef enum logic [1:0] {
        SCL_K_EE,
        SCL_K_SEC,
        SCL_K_LOCK
    } scl_kind_t;

    // Full state of the command sequencer
    typedef struct packed {
        scl_state_t state;
        scl_kind_t  kind;
        logic       locked;
        logic       hs;
        logic       have_data;
        logic [31:0] timer;
        logic       ack_vld;
        logic       ack_ok;
        logic       wdat_vld;
        logic [6:0] wdat_addr;
        logic       wdat_sec;
        logic [7:0] wdat;
        logic       prog_go;
        scl_kind_t  prog_kind;
        logic       prog_abort;
        logic       prog_done;
        logic       busy;
    } scl_cmd_s_t;

    // Shared address pointer state
    typedef struct packed {
        logic [6:0] addr;
        logic       sec;
    } scl_ptr_s_t;

endpackage : scl_pkg

// ==== scl_ptr.sv ====
`timescale 1ns/1ns
`include "scl_map.svh"

module scl_ptr
    import scl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       load,
    input  wire logic [6:0] load_addr,
    input  wire logic       load_sec,
    input  wire logic       page_inc,
    input  wire logic       seq_inc,
    output logic [6:0]      ptr_addr,
    output logic            ptr_sec
);

    scl_ptr_s_t p_q;   // Registered pointer
    scl_ptr_s_t p_d;   // Next pointer

    // Next byte with roll-over to 00h of the same region
    function automatic logic [6:0] seq_next(input logic [6:0] a, input logic sec);
        logic [6:0] n;
        n = a + 7'h01;
        if (sec && a[`SCL_SEC_A_MSB:0] == `SCL_SEC_LAST) begin
            n = `SCL_PTR_RST;
        end else if (!sec && a == `SCL_EE_LAST) begin
            n = `SCL_PTR_RST;
        end
        return n;
    endfunction : seq_next

    ////////////////////////////////////////////////////////////////////////////
    // Next pointer value
    always_comb begin
        p_d = p_q;
        if (clr) begin
            p_d.addr = `SCL_PTR_RST;
            p_d.sec  = 1'b0;
        end else if (load) begin
            p_d.addr = load_addr;
            p_d.sec  = load_sec;
        end else if (page_inc) begin
            // Only the low bits move, page stays
            p_d.addr[`SCL_PAGE_BITS-1:0] = p_q.addr[`SCL_PAGE_BITS-1:0] + 3'h1;
        end else if (seq_inc) begin
            p_d.addr = seq_next(p_q.addr, p_q.sec);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p_q <= '{addr: `SCL_PTR_RST, sec: 1'b0};
        end else begin
            p_q <= p_d;
        end
    end

    assign ptr_addr = p_q.addr;
    assign ptr_sec  = p_q.sec;

endmodule : scl_ptr

// ==== scl_cmd_asserts.sv ====
`timescale 1ns/1ns
// Port-level properties of the command block
module scl_cmd_chk #(
    parameter int WR_CYCLES = 20  // Write cycle length in clocks
)
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       BYTE_VALID,
    input wire logic       STOP,
    input wire logic       LOW_PULSE,
    input wire logic       DISC_RESET,
    input wire logic       ACK_VALID,
    input wire logic       ACK_OK,
    input wire logic       WDAT_VALID,
    input wire logic [6:0] WDAT_ADDR,
    input wire logic       WDAT_SEC,
    input wire logic       PROG_GO,
    input wire logic [1:0] PROG_KIND,
    input wire logic       PROG_ABORT,
    input wire logic       PROG_DONE,
    input wire logic       BUSY,
    input wire logic       LOCKED,
    input wire logic       HIGH_SPEED,
    input wire logic [6:0] PTR_ADDR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    logic [31:0] busy_cnt_q;  // Cycles spent busy so far

    // Busy run length, cleared when idle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= BUSY ? busy_cnt_q + 32'h1 : 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Commit step: stop taken while idle, now busy
    sequence s_commit;
        BUSY && $past(STOP) && !$past(BUSY);
    endsequence
    // Refusal answer
    sequence s_nack;
        ACK_VALID && !ACK_OK;
    endsequence

    a_go_after_stop: assert property (PROG_GO |-> s_commit)
        else $error("write cycle began without a stop");
    a_busy_nacks: assert property (BUSY && LOW_PULSE |=> s_nack)
        else $error("low pulse while busy not refused");
    a_busy_quiet: assert property (BUSY && !LOW_PULSE |=> !ACK_VALID)
        else $error("answer given while busy");
    a_ack_cause: assert property (ACK_VALID |-> $past(BYTE_VALID) || $past(LOW_PULSE))
        else $error("answer without a request");
    a_wdat_acked: assert property (WDAT_VALID |-> ACK_VALID && ACK_OK)
        else $error("staged byte not acknowledged");
    a_sec_upper: assert property (WDAT_VALID && WDAT_SEC |-> WDAT_ADDR[4])
        else $error("security byte staged in lower half");
    a_page_step: assert property (WDAT_VALID |-> PTR_ADDR[4:3] == WDAT_ADDR[4:3]
        && PTR_ADDR[2:0] == WDAT_ADDR[2:0] + 3'h1)
        else $error("pointer did not step within page");
    a_lock_sticky: assert property (LOCKED |=> LOCKED)
        else $error("lock state cleared");
    a_lock_done: assert property (PROG_DONE && PROG_KIND == 2'h2 && !PROG_ABORT |-> ##[0:2] LOCKED)
        else $error("lock cycle ended unlocked");
    a_speed_cause: assert property ($changed(HIGH_SPEED) |-> (ACK_VALID && ACK_OK) || $past(DISC_RESET))
        else $error("speed changed without command");
    a_busy_bound: assert property (BUSY |-> busy_cnt_q <= WR_CYCLES + 2)
        else $error("write cycle overran");
endmodule : scl_cmd_chk

// ==== scl_mst.sv ====
`timescale 1ns/1ns
// Bus master: line events and bytes
module scl_mst (
    input  wire logic       clk,
    input  wire logic       ack_valid,
    input  wire logic       ack_ok,
    output logic [5:0]      ev,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    // Released at time zero
    initial begin
        ev         = 6'h00;
        byte_valid = 1'b0;
        byte_data  = 8'hFF;
    end
    // Answer bit while it stands, z when none
    task automatic answer(output logic a);
        a = ack_valid ? ack_ok : 1'bz;
    endtask : answer
    // One-cycle line event
    task automatic pulse(input logic [5:0] m, output logic a);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 6'h00;
        answer(a);
    endtask : pulse
    // One byte; data inverted once released
    task automatic xfer(input logic [7:0] b, output logic a);
        @(negedge clk);
        byte_valid = 1'b1;
        byte_data  = b;
        @(negedge clk);
        byte_valid = 1'b0;
        byte_data  = ~b;
        answer(a);
    endtask : xfer
endmodule : scl_mst

// ==== tb.sv ====
`timescale 1ns/1ns
// Self-checking bench for the command block
module tb;
    import scl_pkg::*;
    localparam int         WRC = 20;     // Shortened write cycle
    localparam logic [2:0] SID = 3'h5;   // Our slave address
    localparam logic [5:0] STP = 6'h02;  // Stop strobe
    localparam logic [5:0] STA = 6'h01;  // Start strobe

    logic       CLK = 1'b0, RST = 1'b1, LOCK_NV = 1'b0, DISC_RESET = 1'b0, ok;
    logic       START, STOP, STOP_MIDBYTE, BYTE_VALID, RD_BYTE_DONE, LOW_PULSE, ABORT_LONG;
    logic [7:0] BYTE_DATA, WDAT;
    logic [6:0] WDAT_ADDR, PTR_ADDR;
    logic [1:0] PROG_KIND;
    logic       ACK_VALID, ACK_OK, WDAT_VALID, WDAT_SEC, PROG_GO, PROG_ABORT, PROG_DONE;
    logic       BUSY, LOCKED, HIGH_SPEED, PTR_SEC;
    logic [5:0] ev;             // Master line events
    int         err_total = 0;  // Mismatch count
    int         checked   = 0;  // Comparison count

    always #2 CLK = ~CLK;
    assign {ABORT_LONG, LOW_PULSE, RD_BYTE_DONE, STOP_MIDBYTE, STOP, START} = ev;

    scl_cmd #(.WR_CYCLES(WRC)) uut (.CLK(CLK), .RST(RST), .SLAVE_ID(SID), .LOCK_NV(LOCK_NV),
        .DISC_RESET(DISC_RESET), .START(START), .STOP(STOP), .STOP_MIDBYTE(STOP_MIDBYTE),
        .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .RD_BYTE_DONE(RD_BYTE_DONE), .LOW_PULSE(LOW_PULSE),
        .ABORT_LONG(ABORT_LONG), .ACK_VALID(ACK_VALID), .ACK_OK(ACK_OK), .WDAT_VALID(WDAT_VALID),
        .WDAT_ADDR(WDAT_ADDR), .WDAT_SEC(WDAT_SEC), .WDAT(WDAT), .PROG_GO(PROG_GO), .PROG_KIND(PROG_KIND),
        .PROG_ABORT(PROG_ABORT), .PROG_DONE(PROG_DONE), .BUSY(BUSY), .LOCKED(LOCKED),
        .HIGH_SPEED(HIGH_SPEED), .PTR_ADDR(PTR_ADDR), .PTR_SEC(PTR_SEC));
    scl_mst m (.clk(CLK), .ack_valid(ACK_VALID), .ack_ok(ACK_OK), .ev(ev), .byte_valid(BYTE_VALID),
        .byte_data(BYTE_DATA));

    // Compare and count
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Start plus device address byte
    task automatic dev(input logic [3:0] op, input logic rw, output logic a);
        m.pulse(STA, a);
        m.xfer({op, SID, rw}, a);
    endtask : dev
    // Wait out the write cycle with the line released
    task automatic wait_idle();
        for (int i = 0; i < 4 * WRC && BUSY === 1'b1; i++) @(negedge CLK);
        chk(BUSY, 1'b0);
    endtask : wait_idle

    // Speed set and query table, then a foreign slave address
    task automatic t_speed();
        logic [3:0] op [6] = '{4'hD, 4'hD, 4'hE, 4'hE, 4'hE, 4'hD};
        logic [5:0] rw = 6'b110110, ak = 6'b011011, hs = 6'b111000;
        for (int i = 0; i < 6; i++) begin
            dev(op[i], rw[i], ok);
            chk(ok, ak[i]);
            chk(HIGH_SPEED, hs[i]);
            m.pulse(STP, ok);
        end
        m.pulse(STA, ok);
        m.xfer({4'hD, ~SID, 1'b0}, ok);
        chk(ok, 1'b0);
        chk(HIGH_SPEED, 1'b1);
        m.pulse(STP, ok);
        $display("test speed done");
    endtask : t_speed

    // Full security page with wrap, busy refusals, lower-half refusal
    task automatic t_sec();
        dev(4'hB, 1'b0, ok);
        m.xfer(8'hF4, ok);
        chk(ok, 1'b1);
        chk({PTR_SEC, PTR_ADDR[4:0]}, 6'h34);
        for (int i = 0; i < 8; i++) begin
            m.xfer(8'h30 + 8'(i), ok);
            chk(ok, 1'b1);
            chk({WDAT_SEC, WDAT_ADDR[4:0]}, {3'b110, 3'(i + 4)});
            chk(WDAT, 8'h30 + 8'(i));
        end
        m.pulse(STP, ok);
        chk({PROG_GO, BUSY, PROG_KIND}, 4'hD);
        m.pulse(6'h10, ok);
        chk(ok, 1'b0);
        dev(4'hA, 1'b0, ok);
        chk(ok, 1'bz);
        m.pulse(6'h20, ok);
        chk({PROG_ABORT, BUSY}, 2'h2);
        wait_idle();
        chk(PTR_ADDR[4:0], 5'h14);
        dev(4'hB, 1'b0, ok);
        m.xfer(8'h03, ok);
        m.xfer(8'h11, ok);
        chk(ok, 1'b0);
        m.pulse(STP, ok);
        chk(PROG_GO, 1'b0);
        $display("test security write done");
    endtask : t_sec

    // Reset with discovery after standard speed
    task automatic t_disc();
        dev(4'hD, 1'b0, ok);
        m.pulse(STP, ok);
        DISC_RESET = 1'b1;
        @(negedge CLK);
        DISC_RESET = 1'b0;
        chk(HIGH_SPEED, 1'b1);
        chk(PTR_ADDR, 7'h00);
        $display("test discovery done");
    endtask : t_disc

    // Pointer advance, broken stop, region wrap on read
    task automatic t_ptr();
        dev(4'hA, 1'b0, ok);
        m.xfer(8'h0D, ok);
        m.xfer(8'h55, ok);
        chk(PTR_ADDR, 7'h0E);
        m.pulse(STP | 6'h04, ok);
        chk({PROG_GO, PROG_ABORT}, 2'h1);
        dev(4'hB, 1'b0, ok);
        m.xfer(8'hFF, ok);
        dev(4'hB, 1'b1, ok);
        m.pulse(6'h08, ok);
        chk(PTR_ADDR, 7'h00);
        m.pulse(STP, ok);
        $display("test pointer done");
    endtask : t_ptr

    // Check, early stop, lock, refusals once locked, reset
    task automatic t_lock();
        dev(4'h2, 1'b0, ok);
        m.xfer(8'h6A, ok);
        chk(ok, 1'b1);
        m.pulse(STP, ok);
        chk(PROG_GO, 1'b0);
        dev(4'h2, 1'b0, ok);
        m.xfer(8'h63, ok);
        chk(ok, 1'b1);
        m.xfer(8'hA5, ok);
        chk(ok, 1'b1);
        m.pulse(STP, ok);
        chk({PROG_GO, PROG_KIND}, 3'h6);
        wait_idle();
        chk({PROG_DONE, LOCKED}, 2'h3);
        dev(4'h2, 1'b0, ok);
        m.xfer(8'h60, ok);
        chk(ok, 1'b0);
        m.pulse(STP, ok);
        dev(4'hB, 1'b0, ok);
        m.xfer(8'h14, ok);
        chk(ok, 1'b1);
        m.xfer(8'h00, ok);
        chk(ok, 1'b0);
        dev(4'hE, 1'b1, ok);
        chk(ok, 1'b1);
        m.pulse(STP, ok);
        LOCK_NV = 1'b1;
        RST = 1'b1;
        @(negedge CLK);
        RST = 1'b0;
        @(negedge CLK);
        chk({LOCKED, HIGH_SPEED, PTR_ADDR}, 9'h180);
        $display("test lock done");
    endtask : t_lock

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        repeat (12) @(negedge CLK);
        RST = 1'b0;
        @(negedge CLK);
        chk({LOCKED, HIGH_SPEED, PTR_ADDR}, 9'h080);
        t_speed();
        t_sec();
        t_disc();
        t_ptr();
        t_lock();
        conclude();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge CLK);
        err_total++;
        conclude();
    end
endmodule : tb

bind scl_cmd scl_cmd_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (.CLK(CLK), .RST(RST), .BYTE_VALID(BYTE_VALID),
    .STOP(STOP), .LOW_PULSE(LOW_PULSE), .DISC_RESET(DISC_RESET), .ACK_VALID(ACK_VALID), .ACK_OK(ACK_OK),
    .WDAT_VALID(WDAT_VALID), .WDAT_ADDR(WDAT_ADDR), .WDAT_SEC(WDAT_SEC), .PROG_GO(PROG_GO),
    .PROG_KIND(PROG_KIND), .PROG_ABORT(PROG_ABORT), .PROG_DONE(PROG_DONE), .BUSY(BUSY), .LOCKED(LOCKED),
    .HIGH_SPEED(HIGH_SPEED), .PTR_ADDR(PTR_ADDR));
